// ### watchdog_pkg.sv
// Constants, register map and state layout for the watchdog timer.
// Assumes a single 200 MHz clock; the 32.768 kHz rate is a derived enable.
package watchdog_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned SLOW_HZ     = 32_768;
    // Cycles per slow tick, rounded down
    localparam int unsigned TICK_CYCLES = CLK_HZ / SLOW_HZ;
    localparam logic [1:0]  SYNC_LAST   = 2'h3;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_FLAGS    = 8'h00;
    localparam logic [7:0]  OFS_ENABLES  = 8'h04;
    localparam logic [7:0]  OFS_ACK      = 8'h08;
    localparam logic [7:0]  OFS_TRIGGER  = 8'h0c;
    localparam logic [7:0]  OFS_CODE     = 8'h10;
    localparam logic [7:0]  OFS_LIMIT    = 8'h14;
    localparam logic [7:0]  OFS_COUNT    = 8'h18;

    // ------------------------------------------------------------
    // Fields and values
    // ------------------------------------------------------------
    localparam int          EV_EARLY     = 0;
    localparam int          EV_WRAP      = 1;
    localparam int          TRG_ZERO     = 0;
    localparam int          TRG_KICK     = 1;
    localparam int          TRG_LIMIT    = 2;
    localparam int          TRG_NEARWRAP = 3;
    localparam int          TRG_ENABLE   = 4;
    localparam int          NUM_TRG      = 5;
    localparam logic [31:0] EARLY_LEAD   = 32'h0000_0010;
    localparam logic [31:0] NEAR_PRESET  = 32'hffff_ffe0;
    localparam logic [31:0] WRAP_POINT   = 32'hffff_fff0;
    localparam logic [6:0]  CODE_RESET   = 7'h00;
    localparam logic [31:0] LIMIT_RESET  = 32'h0000_0000;
    localparam logic [1:0]  FLAGS_RESET  = 2'h0;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [15:0]               div;
        logic                      tick;
        logic [NUM_TRG-1:0][1:0]   stage;
        logic [6:0]                code_bus;
        logic [31:0]               limit_bus;
        logic                      wd_on;
        logic [31:0]               limit_act;
        logic [31:0]               count;
        logic [1:0]                flags;
        logic [1:0]                enables;
        logic                      nmi;
        logic                      wrap_irq;
        logic                      rst_req;
        logic                      aw_have;
        logic [ADDR_W-1:0]         aw_addr;
        logic                      w_have;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } wd_state_s;

endpackage : watchdog_pkg

// ### watchdog_timer.sv
// Watchdog timer with AXI4-Lite register bank.
// Assumes one clock; the slow 32.768 kHz rate is a one-cycle tick enable.
// The reset request output must be routed to the chip reset controller.
//
// Operation
// - 32-bit counter increments each slow tick while enabled
// - Count reaching limit minus 16 raises early warning, delivered as NMI
// - Count reaching the limit raises a watchdog reset request
// - Reset request is a system reset source for the entire chip
// - Enable code zero enables; any value 1 to 127 disables
// - Trigger bit 4 loads enable code after three slow ticks
// - Trigger bit 2 loads limit value after three slow ticks
// - Trigger bit 1 services the watchdog, restarting the counter
// - Trigger bit 0 clears the counter; writing zero does nothing
// - Trigger bit 3 presets counter to ffffffe0 for quick wrap test
// - Wrap flag at fffffff0, early flag at limit minus 16; both reset zero
// - Each event reaches the processor only when its enable bit is set
// - Writing one to an acknowledge bit clears that flag
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module watchdog_timer
    import watchdog_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
)(
    input  wire logic              clk,           // 200 MHz clock
    input  wire logic              rst,           // Async reset, active high
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
    input  wire logic              s_axi_awvalid, // Write address valid
    output logic                   s_axi_awready, // Write address ready
    input  wire logic [31:0]       s_axi_wdata,   // Write data
    input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
    input  wire logic              s_axi_wvalid,  // Write data valid
    output logic                   s_axi_wready,  // Write data ready
    output logic [1:0]             s_axi_bresp,   // Write response
    output logic                   s_axi_bvalid,  // Write response valid
    input  wire logic              s_axi_bready,  // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
    input  wire logic              s_axi_arvalid, // Read address valid
    output logic                   s_axi_arready, // Read address ready
    output logic [31:0]            s_axi_rdata,   // Read data
    output logic [1:0]             s_axi_rresp,   // Read response
    output logic                   s_axi_rvalid,  // Read data valid
    input  wire logic              s_axi_rready,  // Read data ready
    output logic                   wd_nmi,        // Early warning NMI
    output logic                   wd_wrap_irq,   // Wrap event interrupt
    output logic                   wd_reset_req   // Whole chip reset request
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (TICK_DIV < 2 || TICK_DIV > 65536) begin : g_bad_div
        $error("TICK_DIV out of range");
    end

    localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);

    wd_state_s            st;
    wd_state_s            n;
    logic                 wr_do;
    logic [NUM_TRG-1:0]   trig;
    logic [NUM_TRG-1:0]   apply;
    logic [1:0]           ack;
    logic [1:0]           set_ev;
    logic                 inc;
    logic [7:0]           lane0;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        n      = st;
        n.tick = 1'b0;
        trig   = '0;
        ack    = '0;
        set_ev = '0;
        inc    = 1'b0;
        apply  = '0;
        lane0  = '0;

        // Slow tick divider
        if (st.div == DIV_LAST)
        begin
            n.div  = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.div = st.div + 16'h0001;
        end

        // Write address and data taken in either order
        if (s_axi_awvalid && st.awready)
        begin
            n.aw_have = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            n.w_have = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        wr_do = n.aw_have && n.w_have && !st.bvalid;
        if (wr_do)
        begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            lane0     = n.wdata[7:0] & {8{n.wstrb[0]}};
            case (n.aw_addr[7:2])
                OFS_ENABLES[7:2]: n.enables   = lane0[1:0];
                OFS_ACK[7:2]:     ack         = lane0[1:0];
                OFS_TRIGGER[7:2]: trig        = lane0[NUM_TRG-1:0];
                OFS_CODE[7:2]:    n.code_bus  = lane0[6:0];
                OFS_LIMIT[7:2]:   n.limit_bus = merge(st.limit_bus, n.wdata, n.wstrb);
                OFS_FLAGS[7:2], OFS_COUNT[7:2]: n.bresp = RESP_OKAY;
                default:          n.bresp     = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;

        // Read channel, one outstanding
        if (st.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = '0;
            case (s_axi_araddr[7:2])
                OFS_FLAGS[7:2]:   n.rdata[1:0] = st.flags;
                OFS_ENABLES[7:2]: n.rdata[1:0] = st.enables;
                OFS_ACK[7:2], OFS_TRIGGER[7:2]: n.rdata = '0;
                OFS_CODE[7:2]:    n.rdata[6:0] = st.code_bus;
                OFS_LIMIT[7:2]:   n.rdata      = st.limit_bus;
                OFS_COUNT[7:2]:   n.rdata      = st.count;
                default:          n.rresp      = RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;

        for (int i = 0; i < NUM_TRG; i++)
        begin
            apply[i] = st.tick && (st.stage[i] == SYNC_LAST);
            if (trig[i])
            begin
                n.stage[i] = 2'h1;
            end
            else if (st.tick && st.stage[i] != 2'h0)
            begin
                n.stage[i] = apply[i] ? 2'h0 : st.stage[i] + 2'h1;
            end
        end

        if (apply[TRG_ENABLE])
        begin
            n.wd_on = (st.code_bus == 7'h00);
        end
        if (apply[TRG_LIMIT])
        begin
            n.limit_act = st.limit_bus;
        end

        if (apply[TRG_ZERO] || apply[TRG_KICK])
        begin
            n.count = '0;
        end
        else if (apply[TRG_NEARWRAP])
        begin
            n.count = NEAR_PRESET;
        end
        else if (st.tick && st.wd_on)
        begin
            n.count = st.count + 32'h0000_0001;
            inc     = 1'b1;
        end

        if (inc && n.count == st.limit_act - EARLY_LEAD)
        begin
            set_ev[EV_EARLY] = 1'b1;
        end
        if (inc && n.count == WRAP_POINT)
        begin
            set_ev[EV_WRAP] = 1'b1;
        end

        if (st.tick)
        begin
            n.rst_req = 1'b0;
        end
        if (inc && n.count == st.limit_act)
        begin
            n.rst_req = 1'b1;
        end

        n.flags = (st.flags & ~ack) | set_ev;

        n.nmi      = st.flags[EV_EARLY] & st.enables[EV_EARLY];
        n.wrap_irq = st.flags[EV_WRAP] & st.enables[EV_WRAP];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st           <= '0;
            st.code_bus  <= CODE_RESET;
            st.limit_bus <= LIMIT_RESET;
            st.limit_act <= LIMIT_RESET;
            st.flags     <= FLAGS_RESET;
            st.awready   <= 1'b1;
            st.wready    <= 1'b1;
            st.arready   <= 1'b1;
        end
        else
        begin
            st <= n;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign wd_nmi        = st.nmi;
    assign wd_wrap_irq   = st.wrap_irq;
    assign wd_reset_req  = st.rst_req;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic quiet;
    assign quiet = !(st.tick && (st.stage[TRG_ZERO] == SYNC_LAST
                   || st.stage[TRG_KICK] == SYNC_LAST
                   || st.stage[TRG_NEARWRAP] == SYNC_LAST));

    property p_count_step;
        st.tick && st.wd_on && quiet |=> st.count == $past(st.count) + 32'h0000_0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step");

    property p_hold_off;
        !st.tick && quiet |=> st.count == $past(st.count);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("count moved off tick");

    property p_early;
        st.tick && st.wd_on && quiet
            && st.count + 32'h0000_0001 == st.limit_act - EARLY_LEAD
            |=> st.flags[EV_EARLY];
    endproperty
    a_early: assert property (p_early) else $error("early warning missed");

    property p_limit_reset;
        st.tick && st.wd_on && quiet && st.count + 32'h0000_0001 == st.limit_act
            |=> st.rst_req;
    endproperty
    a_limit_reset: assert property (p_limit_reset) else $error("reset request missed");

    property p_disable;
        apply[TRG_ENABLE] && st.code_bus != 7'h00 |=> !st.wd_on;
    endproperty
    a_disable: assert property (p_disable) else $error("nonzero code enabled");

    property p_kick;
        apply[TRG_KICK] |=> st.count == 32'h0000_0000;
    endproperty
    a_kick: assert property (p_kick) else $error("service did not zero count");

    property p_preset;
        apply[TRG_NEARWRAP] && !apply[TRG_ZERO] && !apply[TRG_KICK]
            |=> st.count == NEAR_PRESET;
    endproperty
    a_preset: assert property (p_preset) else $error("preset value wrong");

    property p_wrap;
        st.tick && st.wd_on && quiet && st.count == WRAP_POINT - 32'h0000_0001
            |=> st.flags[EV_WRAP];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag missed");

    property p_gate;
        !st.enables[EV_EARLY] ##1 !st.enables[EV_EARLY] |-> !wd_nmi;
    endproperty
    a_gate: assert property (p_gate) else $error("masked event reached nmi");

    property p_ack;
        wr_do && ack[EV_EARLY] && !set_ev[EV_EARLY] |=> !st.flags[EV_EARLY];
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge did not clear");

    property p_req_hold;
        st.rst_req && !st.tick |=> st.rst_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("reset request too short");

    // Stage steps 1, 2, 3, then wraps to 0 on the third tick
    property p_trig_latency;
        st.tick && st.stage[TRG_KICK] != 2'h0 && !trig[TRG_KICK]
            |=> st.stage[TRG_KICK] == $past(st.stage[TRG_KICK]) + 2'h1;
    endproperty
    a_trig_latency: assert property (p_trig_latency) else $error("trigger stuck");

    c_nmi:   cover property (st.flags[EV_EARLY] && st.enables[EV_EARLY] ##1 wd_nmi);
    c_reset: cover property (st.rst_req);
    c_wrap:  cover property (st.flags[EV_WRAP]);

endmodule : watchdog_timer

`default_nettype wire

// ### watchdog_timer_tb.sv
// Self-checking testbench for the watchdog timer with AXI4-Lite registers.
// Assumes watchdog_pkg is compiled first; the slow tick is shortened to 8 clocks.
`timescale 1ns/100ps
`default_nettype none

module watchdog_timer_tb
    import watchdog_pkg::*;
;
    localparam int unsigned DIV = 8;

    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    logic              nmi;
    logic              wrap_irq;
    logic              reset_req;
    int                err_total;
    int                total_checks;
    logic [31:0]       v;
    logic [31:0]       c1;

    watchdog_timer #(.TICK_DIV(DIV)) i_dut (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wd_nmi(nmi), .wd_wrap_irq(wrap_irq), .wd_reset_req(reset_req)
    );

    // ------------------------------------------------------------
    // Clock, reset and common tasks
    // ------------------------------------------------------------
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // Unmapped offsets answer an error, everything else OKAY
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw_done;
        bit w_done;
        bit b_done;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        b_done  = 1'b0;
        // No cycle count assumed; only the watchdog ends a hang
        while (!b_done)
        begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            b_done = (bvalid === 1'b1);
        end
        check(bresp, (a >= 8'h1c) ? RESP_SLVERR : RESP_OKAY, "write response");
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bit ar_done;
        bit r_done;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        ar_done = 1'b0;
        r_done  = 1'b0;
        while (!r_done)
        begin
            @(posedge clk);
            if (!ar_done && arready === 1'b1)
            begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
            r_done = (rvalid === 1'b1);
        end
        d = rdata;
        check(rresp, (a >= 8'h1c) ? RESP_SLVERR : RESP_OKAY, "read response");
        rready <= 1'b0;
    endtask : rd

    // Selector 0 waits for the warning, 1 for the reset request
    task automatic wait_hi(input int sel, input int lim);
        for (int n = 0; n < lim; n++)
        begin
            if (((sel == 0) ? nmi : reset_req) === 1'b1)
                break;
            @(posedge clk);
        end
    endtask : wait_hi

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
        begin
            rd(8'(i * 4), v);
            check(v, 32'h0, "reset value or unmapped read");
        end
        wr(8'h1c, 32'hffff_ffff);
        wr(OFS_ENABLES, 32'h3);
        rd(OFS_ENABLES, v);
        check(v, 32'h3, "enables readback");
        wr(OFS_ENABLES, 32'h0);
    endtask : t_reset

    task automatic t_early_and_reset();
        wr(OFS_ENABLES, 32'h1);
        wr(OFS_TRIGGER, 32'h1);
        wr(OFS_LIMIT, 32'd40);
        rd(OFS_LIMIT, v);
        check(v, 32'd40, "limit readback");
        wr(OFS_CODE, 32'h0);
        wr(OFS_TRIGGER, 32'h14);
        wait_hi(0, 600);
        check(nmi, 1'b1, "early warning raised");
        rd(OFS_COUNT, v);
        check(v, 32'd24, "count at early warning");
        rd(OFS_FLAGS, v);
        check(v, 32'h1, "only early flag set");
        check(reset_req, 1'b0, "no reset before limit");
        wr(OFS_ACK, 32'h1);
        rd(OFS_FLAGS, v);
        check(v, 32'h0, "early flag acknowledged");
        repeat (2) @(posedge clk);
        check(nmi, 1'b0, "warning dropped after ack");
        wait_hi(1, 300);
        check(reset_req, 1'b1, "reset request at limit");
        repeat (DIV - 1) @(posedge clk);
        check(reset_req, 1'b1, "request held one tick");
        @(posedge clk);
        check(reset_req, 1'b0, "request released");
    endtask : t_early_and_reset

    task automatic t_service();
        wr(OFS_TRIGGER, 32'h2);
        repeat (3 * DIV + 2) @(posedge clk);
        rd(OFS_COUNT, v);
        check({31'h0, v <= 32'd1}, 32'h1, "service restarts count");
    endtask : t_service

    task automatic t_disable();
        wr(OFS_TRIGGER, 32'h2);
        repeat (3 * DIV + 2) @(posedge clk);
        wr(OFS_ENABLES, 32'h0);
        wr(OFS_CODE, 32'h7f);
        rd(OFS_CODE, v);
        check(v, 32'h7f, "code readback");
        wr(OFS_TRIGGER, 32'h10);
        repeat (3 * DIV + 2) @(posedge clk);
        wr(OFS_TRIGGER, 32'h1);
        repeat (3 * DIV + 2) @(posedge clk);
        rd(OFS_COUNT, c1);
        check(c1, 32'h0, "clear trigger zeroes count");
        // Writing zero to the triggers must be a no-op
        wr(OFS_TRIGGER, 32'h0);
        repeat (5 * DIV) @(posedge clk);
        rd(OFS_COUNT, v);
        check(v, c1, "disabled count holds");
    endtask : t_disable

    task automatic t_wrap();
        wr(OFS_LIMIT, 32'h0);
        wr(OFS_CODE, 32'h0);
        wr(OFS_ENABLES, 32'h1);
        wr(OFS_TRIGGER, 32'h14);
        repeat (3 * DIV + 2) @(posedge clk);
        wr(OFS_TRIGGER, 32'h8);
        repeat (3 * DIV + 2) @(posedge clk);
        rd(OFS_COUNT, v);
        check({31'h0, v >= NEAR_PRESET && v < WRAP_POINT}, 32'h1, "near-wrap preset");
        wait_hi(0, 200);
        rd(OFS_FLAGS, v);
        check(v, 32'h3, "wrap and early flags");
        check(wrap_irq, 1'b0, "masked wrap event");
        wr(OFS_ENABLES, 32'h3);
        repeat (2) @(posedge clk);
        check(wrap_irq, 1'b1, "unmasked wrap event");
        wr(OFS_ACK, 32'h2);
        rd(OFS_FLAGS, v);
        check(v, 32'h1, "wrap flag acknowledged");
        wait_hi(1, 200);
        check(reset_req, 1'b1, "reset on wrap to zero limit");
    endtask : t_wrap

    // ------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // Whole run is near 1000 cycles; allow twenty times that
    initial
    begin
        #(5 * 20000);
        err_total++;
        finish_test();
    end

    initial
    begin
        err_total    = 0;
        total_checks = 0;
        rst     = 1'b1;
        awaddr  = '0;
        awvalid = 1'b0;
        wdata   = '0;
        wstrb   = '0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        araddr  = '0;
        arvalid = 1'b0;
        rready  = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_early_and_reset();
        t_service();
        t_disable();
        t_wrap();
        finish_test();
    end

endmodule : watchdog_timer_tb

`default_nettype wire
